// [hdl/ftcd_divider.sv]
// Prescaler and 6-bit divider that produce the flash timing clock.
module ftcd_divider (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // Configuration
  input  wire logic                          run,
  input  wire logic                          prescale_select,
  input  wire logic [ftcd_pkg::DVAL_W-1:0]   divider_value,
  // Timing clock
  output logic                               flash_clk,
  output logic                               flash_tick
);

  typedef struct packed {
    logic [ftcd_pkg::PRESCALE_W-1:0] pre;
    logic [ftcd_pkg::DVAL_W-1:0]     cnt;
    logic                            tick;
    logic                            clk;
  } ftcd_div_state_t;

  ftcd_div_state_t st;
  ftcd_div_state_t next_st;

  always_comb begin
    logic                        pre_hit;
    logic [ftcd_pkg::DVAL_W-1:0] cnt_new;
    pre_hit = 1'b0;
    cnt_new = '0;
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st = '0;
    end else begin
      pre_hit = !prescale_select || (st.pre == ftcd_pkg::PRESCALE_LAST);
      next_st.pre = prescale_select ? st.pre + 3'h1 : '0;
      if (pre_hit) begin
        // ratio at most 8 times 64
        if (st.cnt >= divider_value) begin
          cnt_new = '0;
          next_st.tick = 1'b1;
        end else begin
          cnt_new = st.cnt + 6'h01;
        end
        next_st.cnt = cnt_new;
        next_st.clk = (cnt_new <= (divider_value >> 1));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flash_clk  = st.clk;
  assign flash_tick = st.tick;

endmodule

// [hdl/ftcd_pkg.sv]
// Shared constants for the flash timing clock divider and its register map.
package ftcd_pkg;

  // APB geometry.
  localparam int          PADDR_W       = 8;
  localparam int          PDATA_W       = 32;
  localparam int          IDX_W         = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0]  IDX_CLKDIV    = 4'h0;
  localparam logic [3:0]  IDX_STATUS    = 4'h5;
  localparam logic [3:0]  IDX_CMD       = 4'h6;
  localparam logic [3:0]  IDX_RSVD2     = 4'h7;
  localparam logic [3:0]  IDX_ADDRHI    = 4'h8;
  localparam logic [3:0]  IDX_ADDRLO    = 4'h9;
  localparam logic [3:0]  IDX_DATAHI    = 4'ha;
  localparam logic [3:0]  IDX_DATALO    = 4'hb;
  localparam logic [3:0]  IDX_RSVD3     = 4'hc;
  localparam logic [3:0]  IDX_RSVD4     = 4'hd;
  localparam logic [3:0]  IDX_RSVD5     = 4'he;

  // Indices 1 to 4 belong to other parts of the flash module.
  localparam logic [3:0]  IDX_FOREIGN_LO = 4'h1;
  localparam logic [3:0]  IDX_FOREIGN_HI = 4'h4;

  // Clock divider register fields.
  localparam int          BIT_LOADED    = 7;
  localparam int          BIT_PRESCALE  = 6;
  localparam int          DVAL_W        = 6;

  // Field masks of the other registers.
  localparam logic [7:0]  STATUS_MASK   = 8'hf7;
  localparam logic [7:0]  CMD_MASK      = 8'h65;
  localparam int          ADDRHI_W      = 6;

  // Reset values.
  localparam logic [7:0]  CLKDIV_RST    = 8'h00;
  localparam logic [7:0]  CMD_RST       = 8'h00;
  localparam logic [7:0]  TEST_RST      = 8'h00;

  // Prescaler and overall ratio limits.
  localparam int          PRESCALE_RATIO = 8;
  localparam int          PRESCALE_W     = 3;
  localparam logic [2:0]  PRESCALE_LAST  = 3'(PRESCALE_RATIO - 1);
  localparam int          MAX_RATIO      = 512;

  // Target band of the flash clock at the oscillator rate.
  localparam int          OSC_KHZ        = 20000;
  localparam int          FCLK_MIN_KHZ   = 150;
  localparam int          FCLK_MAX_KHZ   = 200;
  localparam int          RATIO_LEAST    = (OSC_KHZ + FCLK_MAX_KHZ - 1) / FCLK_MAX_KHZ;
  localparam int          RATIO_MOST     = OSC_KHZ / FCLK_MIN_KHZ;

  // Timed event counter width.
  localparam int          TIMER_W        = 16;

endpackage

// [hdl/ftcd_top.sv]
// Flash timing clock divider with the upper flash register map on APB.

// Contract
// - The divided flash clock is the time base of program and erase timed events.
// - Divider bits 6 to 0 take only the first write after reset and always read back.
// - Bit 7 reads 0 until the divider register is first written, then 1, and ignores writes.
// - Prescale select 0 feeds the oscillator straight in, 1 divides it by 8 first.
// - The combined prescale and divide ratio never exceeds 512.
module ftcd_top #(
  parameter int TIMER_W = ftcd_pkg::TIMER_W
) (
  // Clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [ftcd_pkg::PADDR_W-1:0]      paddr,
  input  wire logic [ftcd_pkg::PDATA_W-1:0]      pwdata,
  input  wire logic [3:0]                        pstrb,
  output logic      [ftcd_pkg::PDATA_W-1:0]      prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Flash timing clock
  output logic                                   flash_clk,
  output logic                                   flash_tick,
  output logic                                   divider_loaded_flag,
  output logic                                   prescale_select,
  output logic      [ftcd_pkg::DVAL_W-1:0]       divider_value,
  output logic                                   divider_write_refused,
  // Timed event counter
  input  wire logic                              timer_start,
  input  wire logic [TIMER_W-1:0]                timer_ticks,
  output logic                                   timer_busy,
  output logic                                   timer_done,
  // Command engine side
  input  wire logic [7:0]                        status_flags,
  output logic                                   status_write,
  output logic      [7:0]                        status_wdata,
  output logic      [7:0]                        command_bits,
  output logic                                   command_write,
  output logic      [ftcd_pkg::ADDRHI_W-1:0]     test_address_high,
  output logic      [7:0]                        test_address_low,
  output logic      [7:0]                        test_data_high,
  output logic      [7:0]                        test_data_low
);

  typedef struct packed {
    // Divider configuration.
    logic                          loaded;
    logic                          prescale;
    logic [ftcd_pkg::DVAL_W-1:0]   dval;
    logic                          refused;
    // Command and status hand-off.
    logic [7:0]                    cmd;
    logic                          cmd_wr;
    logic                          stat_wr;
    logic [7:0]                    stat_wdata;
    // Test registers.
    logic [ftcd_pkg::ADDRHI_W-1:0] addr_hi;
    logic [7:0]                    addr_lo;
    logic [7:0]                    data_hi;
    logic [7:0]                    data_lo;
    // APB answer.
    logic                          ready;
    logic                          err;
    logic [ftcd_pkg::PDATA_W-1:0]  rdata;
    // Timed event counter.
    logic                          busy;
    logic                          done;
    logic [TIMER_W-1:0]            remain;
  } ftcd_top_state_t;

  ftcd_top_state_t st;
  ftcd_top_state_t next_st;

  logic div_clk;
  logic div_tick;

  // Word index of a byte address.
  function automatic logic [ftcd_pkg::IDX_W-1:0] reg_index(
    input logic [ftcd_pkg::PADDR_W-1:0] addr
  );
    return addr[ftcd_pkg::IDX_W+1:2];
  endfunction

  // True for an aligned address that this block answers.
  function automatic logic reg_mapped(
    input logic [ftcd_pkg::PADDR_W-1:0] addr
  );
    logic [ftcd_pkg::IDX_W-1:0] idx;
    logic                       ok;
    idx = reg_index(addr);
    ok  = (addr[1:0] == 2'h0) && (addr[ftcd_pkg::PADDR_W-1:ftcd_pkg::IDX_W+2] == '0);
    if ((idx >= ftcd_pkg::IDX_FOREIGN_LO) && (idx <= ftcd_pkg::IDX_FOREIGN_HI)) begin
      ok = 1'b0;
    end
    if (idx > ftcd_pkg::IDX_RSVD5) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Read value of a mapped register, low byte only.
  function automatic logic [ftcd_pkg::PDATA_W-1:0] read_value(
    input logic [ftcd_pkg::IDX_W-1:0] idx,
    input ftcd_top_state_t            s,
    input logic [7:0]                 stat
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      ftcd_pkg::IDX_CLKDIV: v = {s.loaded, s.prescale, s.dval};
      ftcd_pkg::IDX_STATUS: v = stat & ftcd_pkg::STATUS_MASK;
      ftcd_pkg::IDX_CMD:    v = s.cmd;
      ftcd_pkg::IDX_ADDRHI: v = {2'h0, s.addr_hi};
      ftcd_pkg::IDX_ADDRLO: v = s.addr_lo;
      ftcd_pkg::IDX_DATAHI: v = s.data_hi;
      ftcd_pkg::IDX_DATALO: v = s.data_lo;
      default:              v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction

  always_comb begin
    logic                       setup;
    logic                       access;
    logic                       wr;
    logic [ftcd_pkg::IDX_W-1:0] idx;
    logic [7:0]                 wbyte;
    setup  = psel && !penable;
    access = psel && penable && st.ready;
    idx    = reg_index(paddr);
    wbyte  = pwdata[7:0];
    wr     = access && pwrite && !st.err && pstrb[0];

    next_st            = st;
    next_st.cmd_wr     = 1'b0;
    next_st.stat_wr    = 1'b0;
    next_st.refused    = 1'b0;
    next_st.done       = 1'b0;

    // The answer is prepared in the setup cycle and shown in the access cycle.
    next_st.ready = setup;
    next_st.err   = 1'b0;
    next_st.rdata = '0;
    if (setup) begin
      next_st.err = !reg_mapped(paddr);
      if (!pwrite && reg_mapped(paddr)) begin
        next_st.rdata = read_value(idx, st, status_flags);
      end
    end

    if (wr) begin
      case (idx)
        ftcd_pkg::IDX_CLKDIV: begin
          if (!st.loaded) begin
            next_st.prescale = wbyte[ftcd_pkg::BIT_PRESCALE];
            next_st.dval     = wbyte[ftcd_pkg::DVAL_W-1:0];
            next_st.loaded   = 1'b1;
          end else begin
            next_st.refused  = 1'b1;
          end
        end
        ftcd_pkg::IDX_STATUS: begin
          next_st.stat_wr    = 1'b1;
          next_st.stat_wdata = wbyte & ftcd_pkg::STATUS_MASK;
        end
        ftcd_pkg::IDX_CMD: begin
          next_st.cmd    = wbyte & ftcd_pkg::CMD_MASK;
          next_st.cmd_wr = 1'b1;
        end
        ftcd_pkg::IDX_ADDRHI: next_st.addr_hi = wbyte[ftcd_pkg::ADDRHI_W-1:0];
        ftcd_pkg::IDX_ADDRLO: next_st.addr_lo = wbyte;
        ftcd_pkg::IDX_DATAHI: next_st.data_hi = wbyte;
        ftcd_pkg::IDX_DATALO: next_st.data_lo = wbyte;
        default: begin
        end
      endcase
    end

    if (st.busy && div_tick) begin
      if (st.remain <= TIMER_W'(1)) begin
        next_st.busy   = 1'b0;
        next_st.done   = 1'b1;
        next_st.remain = '0;
      end else begin
        next_st.remain = st.remain - TIMER_W'(1);
      end
    end
    if (timer_start && st.loaded && !st.busy) begin
      next_st.busy   = 1'b1;
      next_st.remain = timer_ticks;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ftcd_divider u_divider (
    .pclk            (pclk),
    .presetn         (presetn),
    .run             (st.loaded),
    .prescale_select (st.prescale),
    .divider_value   (st.dval),
    .flash_clk       (div_clk),
    .flash_tick      (div_tick)
  );

  assign prdata                = st.rdata;
  assign pready                = st.ready;
  assign pslverr               = st.err;
  assign flash_clk             = div_clk;
  assign flash_tick            = div_tick;
  assign divider_loaded_flag   = st.loaded;
  assign prescale_select       = st.prescale;
  assign divider_value         = st.dval;
  assign divider_write_refused = st.refused;
  assign timer_busy            = st.busy;
  assign timer_done            = st.done;
  assign status_write          = st.stat_wr;
  assign status_wdata          = st.stat_wdata;
  assign command_bits          = st.cmd;
  assign command_write         = st.cmd_wr;
  assign test_address_high     = st.addr_hi;
  assign test_address_low      = st.addr_lo;
  assign test_data_high        = st.data_hi;
  assign test_data_low         = st.data_lo;

endmodule

// [verif/ftcd_checker.sv]
// Checker of the APB answer, divider loading and flash tick spacing.
module ftcd_checker (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  // Divider and timer
  input  wire logic        flash_tick,
  input  wire logic        divider_loaded_flag,
  input  wire logic        prescale_select,
  input  wire logic [5:0]  divider_value,
  input  wire logic        divider_write_refused,
  input  wire logic        timer_busy,
  input  wire logic        timer_done
);
  logic [9:0] gap;
  logic       seen;
  logic [9:0] ratio;

  assign ratio = (prescale_select ? 10'h008 : 10'h001) * (10'(divider_value) + 10'h001);

  // Only the spacing between two ticks is judged, so the first tick after loading is free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 10'h000;
      seen <= 1'b0;
    end else begin
      gap  <= flash_tick ? 10'h001 : gap + 10'h001;
      seen <= seen | flash_tick;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_div_write;
    psel && penable && pready && pwrite && paddr == 8'h00 && pstrb[0];
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_loaded_sticky: assert property (divider_loaded_flag |=> divider_loaded_flag)
    else $error("loaded flag dropped");
  a_loaded_cause: assert property ($rose(divider_loaded_flag) |-> $past(pwrite && pready))
    else $error("loaded flag rose without a write");
  a_refuse_second: assert property (s_div_write ##0 divider_loaded_flag |=> divider_write_refused)
    else $error("second divider write not refused");
  a_refuse_cause: assert property (divider_write_refused |-> $past(divider_loaded_flag))
    else $error("refusal without loaded divider");
  a_config_frozen: assert property (divider_loaded_flag |=>
    $stable(prescale_select) && $stable(divider_value))
    else $error("divider config changed after load");
  a_tick_ratio: assert property (flash_tick && seen |-> gap == ratio)
    else $error("flash tick spacing wrong");
  a_tick_idle: assert property (!divider_loaded_flag |-> !flash_tick)
    else $error("flash tick before load");
  a_done_ends_busy: assert property (timer_done |-> !timer_busy && $past(timer_busy))
    else $error("timer done without busy end");
endmodule

// [verif/ftcd_top_bench.sv]
// Self-checking bench for the flash timing clock divider and its registers.
module ftcd_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                          pclk, presetn, psel, penable, pwrite, timer_start;
  logic [7:0]                    paddr, status_flags, status_wdata, command_bits;
  logic [31:0]                   pwdata, prdata;
  logic [3:0]                    pstrb;
  logic [ftcd_pkg::TIMER_W-1:0]  timer_ticks;
  logic                          pready, pslverr, flash_clk, flash_tick, prescale_select;
  logic                          divider_loaded_flag, divider_write_refused, timer_busy;
  logic                          timer_done, status_write, command_write;
  logic [5:0]                    divider_value, test_address_high;
  logic [7:0]                    test_address_low, test_data_high, test_data_low;
  int                            err_total = 0;
  int                            compares = 0;
  int                            cycles = 0;
  // Address, read-back after writing 0xff, and error flag of each place.
  localparam logic [12:0][16:0]  TAB = {17'h06518, 17'h03f20, 17'h0ff24, 17'h0ff28,
    17'h0ff2c, 17'h0001c, 17'h00030, 17'h00034, 17'h00038, 17'h10004, 17'h1003c,
    17'h10002, 17'h10040};

  ftcd_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .flash_clk, .flash_tick, .divider_loaded_flag,
    .prescale_select, .divider_value, .divider_write_refused, .timer_start, .timer_ticks,
    .timer_busy, .timer_done, .status_flags, .status_write, .status_wdata, .command_bits,
    .command_write, .test_address_high, .test_address_low, .test_data_high, .test_data_low);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] exp, input logic eexp);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check(prdata, exp);
    check(32'(pslverr), 32'(eexp));
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_tick(output int n, output int h);
    n = 0;
    h = 0;
    do begin
      @(posedge pclk);
      n++;
      if (flash_clk === 1'b1) h++;
    end while (flash_tick !== 1'b1 && n < 1200);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic t_unloaded();
    logic [16:0] t;
    xfer(1'b1, 8'h00, 32'h45, 4'he, 32'h0, 1'b0);
    xfer(1'b0, 8'h00, 32'h0, 4'hf, 32'h0, 1'b0);
    timer_start <= 1'b1;
    @(posedge pclk);
    timer_start <= 1'b0;
    @(posedge pclk);
    check(32'(timer_busy), 32'h0);
    for (int i = 0; i < 13; i++) begin
      t = TAB[i];
      xfer(1'b0, t[7:0], 32'h0, 4'hf, 32'h0, t[16]);
      xfer(1'b1, t[7:0], 32'hff, 4'hf, 32'h0, t[16]);
      xfer(1'b0, t[7:0], 32'h0, 4'hf, 32'(t[15:8]), t[16]);
    end
    check({command_bits, 2'h0, test_address_high}, 16'h653f);
    check({test_address_low, test_data_high, test_data_low}, 24'hffffff);
    xfer(1'b0, 8'h14, 32'h0, 4'hf, 32'hf7, 1'b0);
    xfer(1'b1, 8'h14, 32'hff, 4'hf, 32'h0, 1'b0);
    @(posedge pclk);
    check({status_write, status_wdata}, 9'h1f7);
    xfer(1'b1, 8'h18, 32'h5a, 4'hf, 32'h0, 1'b0);
    @(posedge pclk);
    check({command_write, command_bits}, 9'h140);
  endtask

  task automatic t_ratio(input logic [7:0] v, input int ratio, input int hi);
    int n;
    int h;
    do_reset();
    xfer(1'b1, 8'h00, 32'(v), 4'h1, 32'h0, 1'b0);
    xfer(1'b0, 8'h00, 32'h0, 4'hf, {24'h0, 1'b1, v[6:0]}, 1'b0);
    check({prescale_select, divider_value}, v[6:0]);
    wait_tick(n, h);
    wait_tick(n, h);
    check(n, ratio);
    check(h, hi);
    xfer(1'b1, 8'h00, ~32'(v), 4'hf, 32'h0, 1'b0);
    @(posedge pclk);
    check(32'(divider_write_refused), 32'h1);
    xfer(1'b0, 8'h00, 32'h0, 4'hf, {24'h0, 1'b1, v[6:0]}, 1'b0);
  endtask

  task automatic t_timer();
    int n;
    int k;
    int h;
    wait_tick(n, h);
    timer_start <= 1'b1;
    timer_ticks <= 16'h0002;
    @(posedge pclk);
    timer_start <= 1'b0;
    n = 0;
    k = 0;
    do begin
      @(posedge pclk);
      if (flash_tick === 1'b1) n++;
      k++;
    end while (timer_done !== 1'b1 && k < 100);
    check(n, 2);
    check(32'(timer_done), 32'h1);
    check(32'(timer_busy), 32'h0);
  endtask

  initial begin
    presetn      = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    pstrb        = 4'h0;
    timer_start  = 1'b0;
    timer_ticks  = 16'h0000;
    status_flags = 8'hff;
    do_reset();
    t_unloaded();
    t_ratio(8'h7f, 512, 256);
    t_ratio(8'h4c, 104, 56);
    t_ratio(8'h05, 6, 3);
    t_timer();
    report_and_stop();
  end
endmodule

bind ftcd_top ftcd_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb,
  .prdata, .pready, .flash_tick, .divider_loaded_flag, .prescale_select, .divider_value,
  .divider_write_refused, .timer_busy, .timer_done);
